// ==== hw/uis_core.sv ====
// interrupt priority, identity, enable, modem control and modem status
// assumes async host strobes and modem pins; same-clock line events
// What this block does
// RULE1: four causes ranked line status, received data, holding empty, modem
// RULE2: reading identity freezes the top cause until that cause is serviced
// RULE3: identity bit 0 reads 0 while an enabled cause pends, else 1
// RULE4: identity bits 2:1 give 11, 10, 01, 00 for the four causes
// RULE5: identity bits 7 to 3 read zero
// RULE6: enable bits 0..3 gate received data, holding empty, line, modem
// RULE7: enable bits 7 to 4 read zero whatever is written
// RULE8: status flags update regardless of enables; enables gate only output
// RULE9: interrupt output high while an enabled cause pends, low otherwise
// RULE10: control bit 0 drives terminal ready; dropping it with strap hangs up
// RULE11: control bits 1 and 2 hold request-to-send and general output a
// RULE12: control bit 3 clear floats the interrupt output, set drives it
// RULE13: control bits 7 to 5 read zero, bit 4 has no function
// RULE14: change flags set on input change, all cleared by status read
// RULE15: status bit 2 sets when ring input goes from on to off
// RULE16: status bit 3 sets on any carrier change
// RULE17: status bits 1:0 read 0, bits 5:4 read 1
// RULE18: status bit 6 is inverted ring pin, bit 7 is carrier state
// RULE19: modem interrupt raised by trailing ring or carrier change flag
// RULE20: receive buffer read clears received-data interrupt within 1 us
// RULE21: holding empty clears on identity read reporting it or data write
// RULE22: holding empty raised within one baud after transmitted stop bit
// RULE23: line status read clears error flags and line interrupt
// RULE24: reset clears enables and control, identity reads 01
// RULE25: after a frozen cause clears, the next top cause is reported
`timescale 1ns/1ns

module uis_core
   import uis_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire uis_pkg::uis_host_t      host_i,
   output logic [7:0]                   data_o,
   output logic                         data_oe_o,
   input  wire uis_pkg::uis_line_t      line_i,
   input  wire uis_pkg::uis_modem_in_t  modem_i,
   output uis_pkg::uis_modem_out_t      modem_o,
   output logic [3:0]                   line_err_o,
   output logic                         tx_holding_empty_o,
   output logic                         tx_load_o,
   output logic                         rx_taken_o,
   output logic                         irq_o,
   output logic                         irq_oe_o
);
   import uis_pkg::*;

   uis_state_t st_q;
   uis_state_t st_d;
   logic       rd_ev;
   logic       wr_ev;
   logic [3:0] pend;
   logic [1:0] top_cause;
   logic [1:0] rep_cause;
   logic       rep_valid;
   logic [7:0] ident_val;

   // shift a pin in; the accepted level moves once stages two and three agree
   function automatic uis_sync_t sync_step(uis_sync_t c, logic pin);
      uis_sync_t r;
      r.s  = {c.s[1:0], pin};
      r.st = (c.s[1] == c.s[2]) ? c.s[2] : c.st;
      return r;
   endfunction : sync_step

   // fixed priority, line status highest, modem status lowest
   function automatic logic [1:0] top_of(logic [3:0] p);
      logic [1:0] c;
      c = UIS_CAUSE_MS;
      if (p[UIS_CAUSE_LS]) begin
         c = UIS_CAUSE_LS;
      end else if (p[UIS_CAUSE_RX]) begin
         c = UIS_CAUSE_RX;
      end else if (p[UIS_CAUSE_TXE]) begin
         c = UIS_CAUSE_TXE;
      end
      return c;
   endfunction : top_of

   always_comb begin
      st_d = st_q;
      st_d.force_cmd = 1'b0;
      st_d.tx_load   = 1'b0;
      st_d.rx_taken  = 1'b0;

      st_d.rd    = sync_step(st_q.rd, host_i.rd_n);
      st_d.wr    = sync_step(st_q.wr, host_i.wr_n);
      st_d.ring  = sync_step(st_q.ring, modem_i.ring_in_n);
      st_d.car   = sync_step(st_q.car, modem_i.carrier_present);
      st_d.strap = sync_step(st_q.strap, modem_i.hangup_strap);

      // chip select and address are stable long before the strobe settles
      rd_ev = st_q.rd.st & ~st_d.rd.st & ~host_i.cs_n;
      wr_ev = st_q.wr.st & ~st_d.wr.st & ~host_i.cs_n;

      // pending causes, each gated by its enable
      pend = '0;
      pend[UIS_CAUSE_LS]   = st_q.ier[UIS_IE_LS] & (|st_q.err);       // RULE6
      pend[UIS_CAUSE_RX]   = st_q.ier[UIS_IE_RX] & st_q.rx_pend;      // RULE6
      pend[UIS_CAUSE_TXE]  = st_q.ier[UIS_IE_TXE] & st_q.txe_pend;    // RULE6
      pend[UIS_CAUSE_MS]   = st_q.ier[UIS_IE_MS]                      // RULE19
                             & (st_q.ring_trailing_flag
                                | st_q.carrier_change_flag);
      top_cause = top_of(pend);                                        // RULE1

      // a frozen cause is reported while it still pends
      if (st_q.frz_v && pend[st_q.frz_cause]) begin                    // RULE2
         rep_cause = st_q.frz_cause;
      end else begin
         rep_cause = top_cause;                                        // RULE25
      end
      rep_valid = |pend;
      ident_val = UIS_IDENT_NONE;                                      // RULE5
      if (rep_valid) begin
         ident_val = {5'h00, rep_cause, 1'b0};                         // RULE3
      end

      // serviced frozen cause releases so the next one is evaluated
      if (st_q.frz_v && !pend[st_q.frz_cause]) begin                   // RULE25
         st_d.frz_v = 1'b0;
      end

      // line status error flags; the set wins over a same-cycle clear
      if (rd_ev && host_i.addr == UIS_ADDR_LSR) begin                  // RULE23
         st_d.err = '0;
      end
      if (line_i.overrun) begin                                        // RULE8
         st_d.err[0] = 1'b1;
      end
      if (line_i.parity_flag) begin
         st_d.err[1] = 1'b1;
      end
      if (line_i.framing_flag) begin
         st_d.err[2] = 1'b1;
      end
      if (line_i.break_flag) begin
         st_d.err[3] = 1'b1;
      end

      // received data cause
      if (rd_ev && host_i.addr == UIS_ADDR_DATA) begin                 // RULE20
         st_d.rx_pend  = 1'b0;
         st_d.rx_taken = 1'b1;
      end
      if (line_i.rx_char) begin
         st_d.rx_pend = 1'b1;
      end

      // holding empty cause
      if (rd_ev && host_i.addr == UIS_ADDR_IDENT && rep_valid
          && rep_cause == UIS_CAUSE_TXE) begin                         // RULE21
         st_d.txe_pend = 1'b0;
      end
      if (wr_ev && host_i.addr == UIS_ADDR_DATA) begin                 // RULE21
         st_d.txe_pend = 1'b0;
         st_d.tx_load  = 1'b1;
      end
      if (line_i.tx_stop_done) begin                                   // RULE22
         st_d.txe_pend = 1'b1;
      end

      // freeze the reported cause when identity is read, except a holding empty cause
      if (rd_ev && host_i.addr == UIS_ADDR_IDENT && rep_valid) begin   // RULE2
         st_d.frz_v     = ~(rep_cause == UIS_CAUSE_TXE);
         st_d.frz_cause = rep_cause;
      end

      // modem change flags run whatever the enables hold
      if (rd_ev && host_i.addr == UIS_ADDR_MSR) begin                  // RULE14
         st_d.ring_trailing_flag  = 1'b0;
         st_d.carrier_change_flag = 1'b0;
      end
      if (!st_q.ring.st && st_d.ring.st) begin                         // RULE15
         st_d.ring_trailing_flag = 1'b1;
      end
      if (st_q.car.st != st_d.car.st) begin                            // RULE16
         st_d.carrier_change_flag = 1'b1;
      end

      // host bus phase and register access
      case (st_q.phase)
         UIS_BUS_IDLE: begin
            if (rd_ev) begin
               st_d.phase = UIS_BUS_READ;
               case (host_i.addr)
                  UIS_ADDR_DATA: st_d.dout = line_i.rx_buffer;
                  UIS_ADDR_IER:  st_d.dout = {4'h0, st_q.ier};         // RULE7
                  UIS_ADDR_IDENT: st_d.dout = ident_val;               // RULE4
                  UIS_ADDR_MCR:  st_d.dout = {3'h0, st_q.mcr};         // RULE13
                  UIS_ADDR_LSR: begin
                     st_d.dout = {1'b0, line_i.tx_shift_empty,
                                  st_q.txe_pend, st_q.err,
                                  line_i.rx_ready};
                  end
                  UIS_ADDR_MSR: begin
                     st_d.dout = {st_q.car.st, ~st_q.ring.st,         // RULE18
                                  UIS_MSR_ONES,                        // RULE17
                                  st_q.carrier_change_flag,
                                  st_q.ring_trailing_flag, 2'h0};
                  end
                  default: st_d.dout = UIS_READ_ZERO;
               endcase
            end else if (wr_ev) begin
               st_d.phase = UIS_BUS_WRITE;
               case (host_i.addr)
                  UIS_ADDR_IER: begin
                     st_d.ier = host_i.data[UIS_IE_W-1:0];             // RULE7
                  end
                  UIS_ADDR_MCR: begin
                     st_d.mcr = host_i.data[UIS_MC_W-1:0];             // RULE11
                     if (st_q.mcr[UIS_MC_DTR]
                         && !host_i.data[UIS_MC_DTR]
                         && st_q.strap.st) begin                       // RULE10
                        st_d.force_cmd = 1'b1;
                     end
                  end
                  default: st_d.phase = UIS_BUS_WRITE;
               endcase
            end
         end
         UIS_BUS_READ: begin
            if (st_d.rd.st) begin
               st_d.phase = UIS_BUS_IDLE;
            end
         end
         UIS_BUS_WRITE: begin
            if (st_d.wr.st) begin
               st_d.phase = UIS_BUS_IDLE;
            end
         end
         default: st_d.phase = UIS_BUS_IDLE;
      endcase
   end

   // synchronous reset loads constants only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin                                                 // RULE24
         st_q.phase               <= UIS_BUS_IDLE;
         st_q.rd                  <= UIS_SYNC_HI;
         st_q.wr                  <= UIS_SYNC_HI;
         st_q.ring                <= UIS_SYNC_HI;
         st_q.car                 <= UIS_SYNC_LO;
         st_q.strap               <= UIS_SYNC_LO;
         st_q.ier                 <= '0;
         st_q.mcr                 <= '0;
         st_q.ring_trailing_flag  <= 1'b0;
         st_q.carrier_change_flag <= 1'b0;
         st_q.err                 <= '0;
         st_q.rx_pend             <= 1'b0;
         st_q.txe_pend            <= 1'b0;
         st_q.frz_v               <= 1'b0;
         st_q.frz_cause           <= UIS_CAUSE_MS;
         st_q.dout                <= UIS_READ_ZERO;
         st_q.force_cmd           <= 1'b0;
         st_q.tx_load             <= 1'b0;
         st_q.rx_taken            <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign data_o             = st_q.dout;
   // read data stands until the strobe is seen released
   assign data_oe_o          = (st_q.phase == UIS_BUS_READ);
   assign line_err_o         = st_q.err;
   assign tx_holding_empty_o = st_q.txe_pend;
   assign tx_load_o          = st_q.tx_load;
   assign rx_taken_o         = st_q.rx_taken;
   assign irq_o              = |pend;                                  // RULE9
   assign irq_oe_o           = st_q.mcr[UIS_MC_GATE];                  // RULE12
   assign modem_o.terminal_ready   = st_q.mcr[UIS_MC_DTR];             // RULE10
   assign modem_o.rts              = st_q.mcr[UIS_MC_RTS];             // RULE11
   assign modem_o.general_output_a = st_q.mcr[UIS_MC_OUTA];            // RULE11
   assign modem_o.force_command    = st_q.force_cmd;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_read_ident;
      rd_ev && host_i.addr == UIS_ADDR_IDENT && st_q.phase == UIS_BUS_IDLE;
   endsequence

   sequence s_read_msr_quiet;
      rd_ev && host_i.addr == UIS_ADDR_MSR && st_q.phase == UIS_BUS_IDLE
      && st_q.car.st == st_d.car.st && !(!st_q.ring.st && st_d.ring.st);
   endsequence

   sequence s_dtr_drop;
      modem_o.terminal_ready ##1 !modem_o.terminal_ready;
   endsequence

   AST_IDENT_IDLE: assert property (                                  // RULE3
      !irq_o |-> ident_val == UIS_IDENT_NONE)
      else $error("identity not idle while no cause pends");

   AST_IDENT_HIGH_ZERO: assert property (                             // RULE5
      s_read_ident |=> data_o[7:3] == 5'h00 && data_oe_o)
      else $error("identity high bits not zero");

   AST_LS_FIRST: assert property (                                    // RULE1
      pend[UIS_CAUSE_LS] && !st_q.frz_v |-> ident_val[2:1] == UIS_CAUSE_LS)
      else $error("line status not reported first");

   AST_IER_HIGH: assert property (                                    // RULE7
      rd_ev && host_i.addr == UIS_ADDR_IER && st_q.phase == UIS_BUS_IDLE
      |=> data_o[7:4] == 4'h0)
      else $error("enable high bits not zero");

   AST_IRQ_LS: assert property (                                      // RULE9
      line_i.parity_flag && st_q.ier[UIS_IE_LS] && !rst_i
      && !(st_d.ier != st_q.ier) |=> irq_o)
      else $error("line error did not raise interrupt");

   AST_GATE_OFF: assert property (                                    // RULE12
      wr_ev && host_i.addr == UIS_ADDR_MCR && st_q.phase == UIS_BUS_IDLE
      && !host_i.data[UIS_MC_GATE] |=> !irq_oe_o)
      else $error("interrupt output still driven with gate clear");

   AST_MSR_CLEAR: assert property (                                   // RULE14
      s_read_msr_quiet |=> !st_q.ring_trailing_flag
      && !st_q.carrier_change_flag)
      else $error("change flags survived status read");

   AST_TRAIL_RING: assert property (                                  // RULE15
      !st_q.ring.st ##1 st_q.ring.st |-> st_q.ring_trailing_flag)
      else $error("trailing ring not flagged");

   AST_CARRIER: assert property (                                     // RULE16
      $changed(st_q.car.st) |-> st_q.carrier_change_flag)
      else $error("carrier change not flagged");

   AST_RX_CLEAR: assert property (                                    // RULE20
      rd_ev && host_i.addr == UIS_ADDR_DATA && st_q.phase == UIS_BUS_IDLE
      && !line_i.rx_char |=> !st_q.rx_pend && rx_taken_o)
      else $error("receive read did not clear data cause");

   AST_TX_HOLDING_EMPTY_SET: assert property (                                    // RULE22
      line_i.tx_stop_done |=> tx_holding_empty_o)
      else $error("holding empty not raised after stop bit");

   AST_HANGUP: assert property (                                      // RULE10
      s_dtr_drop ##0 st_q.strap.st |-> modem_o.force_command)
      else $error("terminal ready drop with strap did not hang up");

   AST_FREEZE: assert property (                                      // RULE2
      s_read_ident ##0 rep_valid && rep_cause != UIS_CAUSE_TXE
      |=> st_q.frz_v)
      else $error("identity read did not freeze cause");

endmodule : uis_core

// ==== hw/uis_pkg.sv ====
// interrupt priority and modem signal register set: shared definitions
// assumes a single 50 MHz clock and a strobed 8-bit host register port
package uis_pkg;

   // register index on the 3-bit host address
   localparam logic [2:0] UIS_ADDR_DATA   = 3'h0;
   localparam logic [2:0] UIS_ADDR_IER    = 3'h1;
   localparam logic [2:0] UIS_ADDR_IDENT  = 3'h2;
   localparam logic [2:0] UIS_ADDR_LSR    = 3'h5;
   localparam logic [2:0] UIS_ADDR_MCR    = 3'h4;
   localparam logic [2:0] UIS_ADDR_MSR    = 3'h6;

   // enable bits
   localparam int UIS_IE_RX     = 0;
   localparam int UIS_IE_TXE    = 1;
   localparam int UIS_IE_LS     = 2;
   localparam int UIS_IE_MS     = 3;
   localparam int UIS_IE_W      = 4;

   // modem control bits
   localparam int UIS_MC_DTR    = 0;
   localparam int UIS_MC_RTS    = 1;
   localparam int UIS_MC_OUTA   = 2;
   localparam int UIS_MC_GATE   = 3;
   localparam int UIS_MC_W      = 5;

   // cause codes, also the identity bits 2:1
   localparam logic [1:0] UIS_CAUSE_LS   = 2'h3;
   localparam logic [1:0] UIS_CAUSE_RX   = 2'h2;
   localparam logic [1:0] UIS_CAUSE_TXE  = 2'h1;
   localparam logic [1:0] UIS_CAUSE_MS   = 2'h0;

   // modem status constant bits 5:4 and idle identity value
   localparam logic [1:0] UIS_MSR_ONES    = 2'h3;
   localparam logic [7:0] UIS_IDENT_NONE  = 8'h01;
   localparam logic [7:0] UIS_READ_ZERO   = 8'h00;

   typedef enum logic [2:0] {
      UIS_BUS_IDLE  = 3'b001,
      UIS_BUS_READ  = 3'b010,
      UIS_BUS_WRITE = 3'b100
   } uis_bus_phase_t;

   // three-stage pin synchroniser with the accepted level
   typedef struct packed {
      logic [2:0] s;
      logic       st;
   } uis_sync_t;

   localparam uis_sync_t UIS_SYNC_HI = '{s: 3'h7, st: 1'b1};
   localparam uis_sync_t UIS_SYNC_LO = '{s: 3'h0, st: 1'b0};

   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic [2:0] addr;
      logic [7:0] data;
   } uis_host_t;

   // pulses and levels from the receiver and transmitter
   typedef struct packed {
      logic       overrun;
      logic       parity_flag;
      logic       framing_flag;
      logic       break_flag;
      logic       rx_char;
      logic       tx_stop_done;
      logic       rx_ready;
      logic       tx_shift_empty;
      logic [7:0] rx_buffer;
   } uis_line_t;

   typedef struct packed {
      logic ring_in_n;
      logic carrier_present;
      logic hangup_strap;
   } uis_modem_in_t;

   typedef struct packed {
      logic terminal_ready;
      logic rts;
      logic general_output_a;
      logic force_command;
   } uis_modem_out_t;

   typedef struct packed {
      uis_bus_phase_t phase;
      uis_sync_t      rd;
      uis_sync_t      wr;
      uis_sync_t      ring;
      uis_sync_t      car;
      uis_sync_t      strap;
      logic [3:0]     ier;
      logic [4:0]     mcr;
      logic           ring_trailing_flag;
      logic           carrier_change_flag;
      logic [3:0]     err;
      logic           rx_pend;
      logic           txe_pend;
      logic           frz_v;
      logic [1:0]     frz_cause;
      logic [7:0]     dout;
      logic           force_cmd;
      logic           tx_load;
      logic           rx_taken;
   } uis_state_t;

endpackage : uis_pkg

// ==== bench/uis_host_model.sv ====
// host cpu model: strobed register reads and writes on the 8-bit port
// assumes the register block samples strobes through a 3-flop synchroniser
`timescale 1ns/1ns

module uis_host_model
   import uis_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic [7:0]    data_i,
   output uis_pkg::uis_host_t host_o
);
   initial begin
      host_o = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h7, data: 8'h00};
   end

   // six edges low and five high give the synchroniser margin on both sides
   task automatic access(input  logic       wr,
                         input  logic [2:0] a,
                         input  logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clk_i);
      host_o.cs_n <= 1'b0;
      host_o.addr <= a;
      host_o.data <= d;
      if (wr) begin
         host_o.wr_n <= 1'b0;
      end else begin
         host_o.rd_n <= 1'b0;
      end
      repeat (6) @(posedge clk_i);
      q = data_i;
      host_o.rd_n <= 1'b1;
      host_o.wr_n <= 1'b1;
      repeat (5) @(posedge clk_i);
      host_o.cs_n <= 1'b1;
      // released lines show a changed pattern, never the last value
      host_o.addr <= ~a;
      host_o.data <= ~d;
   endtask : access
endmodule : uis_host_model

// ==== bench/tb_top.sv ====
// self-checking bench for the interrupt and modem register block
// assumes uis_core alone, host cpu model on the register port
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
   bad_count++; $display("wrong value %s exp %h got %h", nm, exp, got); \
   end end

module tb_top;
   import uis_pkg::*;
   logic           clk_i = 1'b0;
   logic           rst_i = 1'b1;
   uis_host_t      host;
   logic [7:0]     data_o;
   uis_line_t      ln = '0;
   uis_modem_in_t  md = '{ring_in_n: 1'b1, carrier_present: 1'b0,
                          hangup_strap: 1'b0};
   uis_modem_out_t mo;
   logic           irq_o;
   logic           irq_oe_o;
   int             bad_count = 0;
   int             checked = 0;
   int             fc_cnt = 0;
   logic           data_oe;
   logic [3:0]     lerr;
   logic           txe;
   logic           txl;
   logic           rxt;
   int             tl_cnt = 0;
   int             rt_cnt = 0;
   int             oe_cnt = 0;

   always #10 clk_i = ~clk_i;

   uis_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .host_i(host),
      .data_o(data_o), .data_oe_o(data_oe), .line_i(ln), .modem_i(md),
      .modem_o(mo), .line_err_o(lerr), .tx_holding_empty_o(txe),
      .tx_load_o(txl), .rx_taken_o(rxt), .irq_o(irq_o),
      .irq_oe_o(irq_oe_o));

   uis_host_model i_host (.clk_i(clk_i), .data_i(data_o), .host_o(host));

   always @(posedge clk_i) begin
      if (mo.force_command === 1'b1) begin
         fc_cnt++;
      end
      if (txl === 1'b1) begin
         tl_cnt++;
      end
      if (rxt === 1'b1) begin
         rt_cnt++;
      end
      if (data_oe === 1'b1) begin
         oe_cnt++;
      end
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      i_host.access(1'b1, a, d, q);
   endtask : wr

   task automatic rdchk(input logic [2:0] a, input logic [7:0] m,
                        input logic [7:0] e);
      logic [7:0] q;
      i_host.access(1'b0, a, 8'h00, q);
      `CHK($sformatf("reg %0d", a), e, q & m)
   endtask : rdchk

   task automatic pulse(input logic [5:0] p);
      @(posedge clk_i);
      ln[15:10] <= p;
      @(posedge clk_i);
      ln[15:10] <= 6'h00;
      @(negedge clk_i);
   endtask : pulse

   task automatic settle;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
   endtask : settle

   task automatic t_reset;
      `CHK("irq_oe", 1'b0, irq_oe_o)
      `CHK("data_oe", 1'b0, data_oe)
      rdchk(UIS_ADDR_IER, 8'hff, 8'h00);
      rdchk(UIS_ADDR_MCR, 8'hff, 8'h00);
      rdchk(UIS_ADDR_IDENT, 8'hff, UIS_IDENT_NONE);
      rdchk(UIS_ADDR_MSR, 8'hff, 8'h30);
      // read data stands from the taken edge until the release is seen
      `CHK("data_oe", 24, oe_cnt)
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs;
      wr(UIS_ADDR_IER, 8'hff);
      rdchk(UIS_ADDR_IER, 8'hff, 8'h0f);
      wr(UIS_ADDR_MCR, 8'hff);
      rdchk(UIS_ADDR_MCR, 8'he0, 8'h00);
      `CHK("dtr", 1'b1, mo.terminal_ready)
      `CHK("rts", 1'b1, mo.rts)
      `CHK("out_a", 1'b1, mo.general_output_a)
      `CHK("irq_oe", 1'b1, irq_oe_o)
      wr(UIS_ADDR_MCR, 8'h08);
      `CHK("dtr", 1'b0, mo.terminal_ready)
      $display("test registers done");
   endtask : t_regs

   task automatic t_prio;
      ln.rx_buffer <= 8'ha5;
      pulse(6'b010011);
      `CHK("irq", 1'b1, irq_o)
      `CHK("line_err", 4'h2, lerr)
      `CHK("tx_empty", 1'b1, txe)
      rdchk(UIS_ADDR_IDENT, 8'hff, 8'h06);
      rdchk(UIS_ADDR_LSR, 8'h04, 8'h04);
      `CHK("line_err", 4'h0, lerr)
      rdchk(UIS_ADDR_IDENT, 8'hff, 8'h04);
      rdchk(UIS_ADDR_DATA, 8'hff, 8'ha5);
      `CHK("rx_taken", 1, rt_cnt)
      rdchk(UIS_ADDR_IDENT, 8'hff, 8'h02);
      rdchk(UIS_ADDR_IDENT, 8'hff, 8'h01);
      `CHK("tx_empty", 1'b0, txe)
      `CHK("irq", 1'b0, irq_o)
      pulse(6'b000001);
      `CHK("irq", 1'b1, irq_o)
      wr(UIS_ADDR_DATA, 8'h5a);
      `CHK("tx_load", 1, tl_cnt)
      `CHK("tx_empty", 1'b0, txe)
      rdchk(UIS_ADDR_IDENT, 8'hff, 8'h01);
      $display("test priority done");
   endtask : t_prio

   task automatic t_modem;
      wr(UIS_ADDR_IER, 8'h00);
      md.carrier_present <= 1'b1;
      settle();
      `CHK("irq", 1'b0, irq_o)
      rdchk(UIS_ADDR_MSR, 8'hff, 8'hb8);
      wr(UIS_ADDR_IER, 8'h08);
      md.ring_in_n <= 1'b0;
      settle();
      rdchk(UIS_ADDR_MSR, 8'hff, 8'hf0);
      md.ring_in_n <= 1'b1;
      settle();
      `CHK("irq", 1'b1, irq_o)
      rdchk(UIS_ADDR_IDENT, 8'hff, 8'h00);
      rdchk(UIS_ADDR_MSR, 8'hff, 8'hb4);
      rdchk(UIS_ADDR_IDENT, 8'hff, 8'h01);
      md.carrier_present <= 1'b0;
      settle();
      rdchk(UIS_ADDR_IDENT, 8'hff, 8'h00);
      rdchk(UIS_ADDR_MSR, 8'hff, 8'h38);
      $display("test modem status done");
   endtask : t_modem

   task automatic t_hangup;
      md.hangup_strap <= 1'b1;
      settle();
      wr(UIS_ADDR_MCR, 8'h09);
      `CHK("hangup", 0, fc_cnt)
      wr(UIS_ADDR_MCR, 8'h08);
      `CHK("hangup", 1, fc_cnt)
      wr(UIS_ADDR_MCR, 8'h00);
      `CHK("irq_oe", 1'b0, irq_oe_o)
      $display("test hangup done");
   endtask : t_hangup

   task automatic t_rerun;
      wr(UIS_ADDR_IER, 8'h0f);
      wr(UIS_ADDR_MCR, 8'h0f);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      `CHK("irq_oe", 1'b0, irq_oe_o)
      `CHK("dtr", 1'b0, mo.terminal_ready)
      rdchk(UIS_ADDR_IER, 8'hff, 8'h00);
      rdchk(UIS_ADDR_IDENT, 8'hff, UIS_IDENT_NONE);
      $display("test mid-run reset done");
   endtask : t_rerun

   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      conclude();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      t_reset();
      t_regs();
      t_prio();
      t_modem();
      t_hangup();
      t_rerun();
      conclude();
   end
endmodule : tb_top
